// >>> rtl/serial_regs_pkg.sv
// Behaviour
// - Control bit 1 reads 1 when transmit buffer empty, 0 while it holds data.
// - Control bit 3 reads 1 while receive buffer holds unread data.
// - Reading receive buffer upper byte clears the receive-complete flag.
// - Bit 4 selects transmit request: buffer empty (0) or shifter done (1).
// - Bit 5 turns continuous receive on (1) or off (0).
// - Receive buffer holds data bits 7..0 low and ninth bit at bit 8.
// - Overrun, framing, parity, error-sum flags sit at bits 12 to 15.
// - Error flags clear when mode is written disabled or receive enable clears.
// - Error-sum reads 0 exactly when the other three error flags are 0.
// - Upper byte read also clears parity and framing flags, not overrun.
// - In clock-synchronous mode framing, parity, error-sum flags are meaningless.
// - Receive buffer bits 11:9 undefined; control bits 7:6 read 0.
// - Transmit pin select bits 1:0: none, first, alternate, reserved as none.
// - Receive pin select bits 3:2: none, first, alternate, reserved as none.
// - Clock pin select bits 5:4: none, first, alternate, reserved as none.
// - Transmit-complete condition follows the shift register empty flag.
`default_nettype none
package serial_regs_pkg;
   // Register indices; byte address is four times the index
   localparam logic [9:0] CTRL1_IDX = 10'h0A5;
   localparam logic [9:0] RXBUF_IDX = 10'h0A6;
   localparam logic [9:0] RXBUF_HI_IDX = 10'h0A7;
   localparam logic [9:0] ROUTE_IDX = 10'h188;
   localparam logic [9:0] MODE_IDX = 10'h0A0;
   localparam logic [7:0] CTRL1_RESET = 8'h02;
   localparam logic [7:0] ROUTE_RESET = 8'h00;
   localparam logic [2:0] MODE_RESET = 3'h0;
   // Control register 1 fields
   localparam int TX_EN_BIT = 0;
   localparam int TX_EMPTY_BIT = 1;
   localparam int RX_EN_BIT = 2;
   localparam int RX_DONE_BIT = 3;
   localparam int IRQ_SEL_BIT = 4;
   localparam int CONT_RX_BIT = 5;
   // Receive buffer fields
   localparam int NINTH_BIT = 8;
   localparam int OVR_BIT = 12;
   localparam int FRM_BIT = 13;
   localparam int PAR_BIT = 14;
   localparam int SUM_BIT = 15;
   // Mode codes
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_SYNC = 3'h1;
   // Pin route codes
   localparam logic [1:0] ROUTE_FIRST = 2'h1;
   localparam logic [1:0] ROUTE_ALT = 2'h2;
   // Bus answer state
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_DONE = 1'b1
   } bus_state_t;
endpackage
`default_nettype wire

// >>> rtl/serial_port_control_status.sv
// The implementer's own choice: register access over Avalon-MM.
`default_nettype none
module serial_port_control_status
   import serial_regs_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // Avalon-MM slave
   input  wire logic [11:0] address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   output logic      [1:0]  response,
   // Transmit path events from the shifter
   input  wire logic        tx_load,
   input  wire logic        tx_take,
   input  wire logic        shift_empty,
   // Receive path events from the shifter
   input  wire logic        rx_done,
   input  wire logic [8:0]  rx_data,
   input  wire logic        rx_overrun,
   input  wire logic        rx_framing,
   input  wire logic        rx_parity,
   // Pins from the remote device, asynchronous
   input  wire logic        rx_pin_first,
   input  wire logic        rx_pin_alt,
   input  wire logic        clk_pin_first_in,
   input  wire logic        clk_pin_alt_in,
   // Routed internal signals
   input  wire logic        tx_serial,
   input  wire logic        clk_out,
   input  wire logic        clk_out_en,
   output logic             rx_serial,
   output logic             clk_in,
   output logic             tx_pin_first,
   output logic             tx_pin_first_oe,
   output logic             tx_pin_alt,
   output logic             tx_pin_alt_oe,
   output logic             clk_pin_first,
   output logic             clk_pin_first_oe,
   output logic             clk_pin_alt,
   output logic             clk_pin_alt_oe,
   // Control seen by the shifter
   output logic             transmit_enable,
   output logic             receive_enable,
   output logic             continuous_rx_enable,
   output logic      [2:0]  serial_mode,
   output logic             tx_request
);

   // Route decode, reserved code treated as unused
   function automatic logic [1:0] route_dec(input logic [1:0] code);
      route_dec = {code == ROUTE_ALT, code == ROUTE_FIRST};
   endfunction

   logic [7:0]  ctrl_q;
   logic [7:0]  route_q;
   logic [2:0]  mode_q;
   logic [8:0]  data_q;
   logic        ovr_q, frm_q, par_q;
   logic        tx_empty_q, rx_full_q, shift_empty_q;
   bus_state_t  state_q;
   logic [31:0] rd_q;
   logic [1:0]  resp_q;
   logic [1:0]  rxs1_q, rxs2_q, cks1_q, cks2_q;
   logic        rx_serial_q, clk_in_q;
   logic [5:0]  pin_q;
   logic        tx_req_q;

   // Address decode on word index
   wire [9:0] idx     = address[11:2];
   wire       acc     = (read | write) && state_q == BUS_IDLE;
   wire       wr      = acc & write;
   wire       rd      = acc & read;
   wire       hit_c   = idx == CTRL1_IDX;
   wire       hit_rb  = idx == RXBUF_IDX;
   wire       hit_rh  = idx == RXBUF_HI_IDX;
   wire       hit_rt  = idx == ROUTE_IDX;
   wire       hit_m   = idx == MODE_IDX;
   wire       mapped  = hit_c | hit_rb | hit_rh | hit_rt | hit_m;
   wire       wr_c    = wr & hit_c & byteenable[0];
   wire       wr_rt   = wr & hit_rt & byteenable[0];
   wire       wr_m    = wr & hit_m & byteenable[0];
   // Upper byte read: 16-bit read of the buffer or the high index
   wire       rd_hi   = rd & ((hit_rb & byteenable[1]) | (hit_rh & byteenable[0]));

   // Error clear on disabled mode write or receive enable going low
   wire       err_clr = (wr_m && writedata[2:0] == MODE_OFF) |
                        (wr_c && !writedata[RX_EN_BIT]);
   wire       sum     = ovr_q | frm_q | par_q;
   wire [7:0] ctrl_rd = {2'b00, ctrl_q[CONT_RX_BIT], ctrl_q[IRQ_SEL_BIT], rx_full_q,
                         ctrl_q[RX_EN_BIT], tx_empty_q, ctrl_q[TX_EN_BIT]};
   // Flags read raw in synchronous mode; they carry no meaning there
   wire [15:0] rb_rd  = {sum, par_q, frm_q, ovr_q, 3'b000, data_q};
   wire [31:0] rd_mux = hit_c  ? {24'h000000, ctrl_rd} :
                        hit_rb ? {16'h0000, rb_rd} :
                        hit_rh ? {24'h000000, rb_rd[15:8]} :
                        hit_rt ? {24'h000000, 2'b00, route_q[5:0]} :
                        hit_m  ? {29'h00000000, mode_q} : 32'h00000000;
   // Transmit request source
   wire       tx_req_d = ctrl_q[IRQ_SEL_BIT] ? shift_empty_q : tx_empty_q;

   wire [1:0] tsel = route_dec(route_q[1:0]);
   wire [1:0] rsel = route_dec(route_q[3:2]);
   wire [1:0] csel = route_dec(route_q[5:4]);

   // Bus answer: one wait cycle, then waitrequest low with data
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_q <= BUS_IDLE;
         rd_q    <= 32'h00000000;
         resp_q  <= 2'h0;
      end else begin
         case (state_q)
            BUS_IDLE: begin
               if (read | write) begin
                  state_q <= BUS_DONE;
                  rd_q    <= read ? rd_mux : 32'h00000000;
                  resp_q  <= mapped ? 2'h0 : 2'h3;
               end
            end
            BUS_DONE: state_q <= BUS_IDLE;
            default:  state_q <= BUS_IDLE;
         endcase
      end
   end

   // Software control fields
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ctrl_q  <= CTRL1_RESET;
         route_q <= ROUTE_RESET;
         mode_q  <= MODE_RESET;
      end else begin
         if (wr_c)
            ctrl_q <= {2'b00, writedata[5:4], 1'b0, writedata[2], 1'b0, writedata[0]};
         if (wr_rt)
            route_q <= {2'b00, writedata[5:0]};
         if (wr_m)
            mode_q <= writedata[2:0];
      end
   end

   // Buffer flags; tx_load wins over tx_take, rx_done wins over the upper byte read clear
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tx_empty_q    <= 1'b1;
         rx_full_q     <= 1'b0;
         shift_empty_q <= 1'b1;
         data_q        <= 9'h000;
      end else begin
         shift_empty_q <= shift_empty;
         if (tx_load)
            tx_empty_q <= 1'b0;
         else if (tx_take)
            tx_empty_q <= 1'b1;
         if (rx_done) begin
            rx_full_q <= 1'b1;
            data_q    <= rx_data;
         end else if (rd_hi)
            rx_full_q <= 1'b0;
      end
   end

   // Error flags
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ovr_q <= 1'b0;
         frm_q <= 1'b0;
         par_q <= 1'b0;
      end else begin
         if (rx_done && rx_overrun)
            ovr_q <= 1'b1;
         else if (err_clr)
            ovr_q <= 1'b0;
         if (rx_done && rx_framing)
            frm_q <= 1'b1;
         else if (err_clr | rd_hi)
            frm_q <= 1'b0;
         if (rx_done && rx_parity)
            par_q <= 1'b1;
         else if (err_clr | rd_hi)
            par_q <= 1'b0;
      end
   end

   // Pin input synchronisers
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rxs1_q <= 2'h0;
         rxs2_q <= 2'h0;
         cks1_q <= 2'h0;
         cks2_q <= 2'h0;
      end else begin
         rxs1_q <= {rx_pin_alt, rx_pin_first};
         rxs2_q <= rxs1_q;
         cks1_q <= {clk_pin_alt_in, clk_pin_first_in};
         cks2_q <= cks1_q;
      end
   end

   // Routed signals, all registered; idle line high when unrouted
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rx_serial_q <= 1'b1;
         clk_in_q    <= 1'b1;
         pin_q       <= 6'h00;
         tx_req_q    <= 1'b0;
      end else begin
         rx_serial_q <= rsel[0] ? rxs2_q[0] : rsel[1] ? rxs2_q[1] : 1'b1;
         clk_in_q    <= csel[0] ? cks2_q[0] : csel[1] ? cks2_q[1] : 1'b1;
         pin_q       <= {csel[1] & clk_out_en, csel[0] & clk_out_en,
                         tsel[1], tsel[0], tx_serial, clk_out};
         tx_req_q    <= tx_req_d;
      end
   end

   assign readdata             = rd_q;
   assign waitrequest          = ~(state_q == BUS_DONE);
   assign response             = resp_q;
   assign transmit_enable      = ctrl_q[TX_EN_BIT];
   assign receive_enable       = ctrl_q[RX_EN_BIT];
   assign continuous_rx_enable = ctrl_q[CONT_RX_BIT];
   assign serial_mode          = mode_q;
   assign tx_request           = tx_req_q;
   assign rx_serial            = rx_serial_q;
   assign clk_in               = clk_in_q;
   assign tx_pin_first         = pin_q[1];
   assign tx_pin_first_oe      = pin_q[2];
   assign tx_pin_alt           = pin_q[1];
   assign tx_pin_alt_oe        = pin_q[3];
   assign clk_pin_first        = pin_q[0];
   assign clk_pin_first_oe     = pin_q[4];
   assign clk_pin_alt          = pin_q[0];
   assign clk_pin_alt_oe       = pin_q[5];

endmodule
`default_nettype wire

// >>> bench/serial_port_asserts.sv
`default_nettype none
module serial_port_asserts
   import serial_regs_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        reset,
   input wire logic [11:0] address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [3:0]  byteenable,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic [1:0]  response,
   input wire logic        tx_pin_first_oe,
   input wire logic        tx_pin_alt_oe,
   input wire logic        clk_pin_first_oe,
   input wire logic        clk_pin_alt_oe,
   input wire logic        transmit_enable,
   input wire logic        receive_enable,
   input wire logic        continuous_rx_enable,
   input wire logic [2:0]  serial_mode
);
   // Request decode
   wire logic [9:0] idx = address[11:2];
   wire logic       ans = !waitrequest && (read || write);
   wire logic       take = waitrequest && write && byteenable[0];
   wire logic       mapped = idx inside {CTRL1_IDX, RXBUF_IDX, RXBUF_HI_IDX, ROUTE_IDX, MODE_IDX};
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   AST_ONE_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered after one cycle");
   AST_LOW_ONE: assert property (!waitrequest |=> waitrequest)
      else $error("answer held longer than one cycle");
   AST_CTRL_TOP_ZERO: assert property (ans && read && idx == CTRL1_IDX |-> readdata[7:6] == 2'h0)
      else $error("control top bits not zero");
   AST_SUM_IS_OR: assert property (ans && read && idx == RXBUF_IDX && serial_mode != MODE_SYNC
      |-> readdata[SUM_BIT] == |readdata[PAR_BIT:OVR_BIT]) else $error("error sum wrong");
   AST_UNMAPPED: assert property (ans && !mapped |-> response == 2'h3 && readdata == 32'h0)
      else $error("unmapped access not refused");
   AST_MAPPED_OK: assert property (ans && mapped |-> response == 2'h0)
      else $error("mapped access refused");
   AST_CTRL_WRITE: assert property (take && idx == CTRL1_IDX |=> {continuous_rx_enable,
      receive_enable, transmit_enable} == {$past(writedata[CONT_RX_BIT]),
      $past(writedata[RX_EN_BIT]), $past(writedata[TX_EN_BIT])}) else $error("enables wrong");
   AST_MODE_WRITE: assert property (take && idx == MODE_IDX |=> serial_mode == $past(writedata[2:0]))
      else $error("mode not written");
   AST_TX_ONE_PIN: assert property (!(tx_pin_first_oe && tx_pin_alt_oe))
      else $error("two transmit pins driven");
   AST_CLK_ONE_PIN: assert property (!(clk_pin_first_oe && clk_pin_alt_oe))
      else $error("two clock pins driven");
   COV_ERR_READ: cover property (ans && read && idx == RXBUF_IDX && readdata[SUM_BIT]);
   COV_UNMAPPED: cover property (ans && !mapped);
   COV_ALT_PIN: cover property (tx_pin_alt_oe);
endmodule
bind serial_port_control_status serial_port_asserts serial_port_asserts_i (.ref_clk, .reset,
   .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .response,
   .tx_pin_first_oe, .tx_pin_alt_oe, .clk_pin_first_oe, .clk_pin_alt_oe, .transmit_enable,
   .receive_enable, .continuous_rx_enable, .serial_mode);
`default_nettype wire

// >>> bench/remote_serial_model.sv
`default_nettype none
module remote_serial_model (
   output logic rx_pin_first,
   output logic rx_pin_alt,
   output logic clk_pin_first_in,
   output logic clk_pin_alt_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Opposite levels per pin so the routing shows which pin is heard
   assign rx_pin_first = 1'b0;
   assign rx_pin_alt = 1'b1;
   assign clk_pin_first_in = 1'b1;
   assign clk_pin_alt_in = 1'b0;
endmodule
`default_nettype wire

// >>> bench/serial_port_control_status_tb.sv
`default_nettype none
module serial_port_control_status_tb;
   import serial_regs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk, reset, read, write, waitrequest, tx_load, tx_take, shift_empty;
   logic        rx_done, rx_ovr, rx_frm, rx_par, rx_pf, rx_pa, ck_pf, ck_pa, rx_serial;
   logic        clk_in, tpf_oe, tpa_oe, cpf_oe, cpa_oe, txrq;
   logic        tx_ser, ck_out, tpf, tpa, cpf, cpa;
   logic [11:0] address;
   logic [31:0] writedata, readdata, rd;
   logic [1:0]  response, rsp;
   logic [8:0]  rx_data;
   int          err_total, n_compared;
   serial_port_control_status serial_port_control_status_i (.ref_clk, .reset, .address,
      .read, .write, .writedata, .byteenable(4'hF), .readdata, .waitrequest, .response,
      .tx_load, .tx_take, .shift_empty, .rx_done, .rx_data, .rx_overrun(rx_ovr),
      .rx_framing(rx_frm), .rx_parity(rx_par), .rx_pin_first(rx_pf), .rx_pin_alt(rx_pa),
      .clk_pin_first_in(ck_pf), .clk_pin_alt_in(ck_pa), .tx_serial(tx_ser), .clk_out(ck_out),
      .clk_out_en(1'b1), .rx_serial, .clk_in, .tx_pin_first(tpf), .tx_pin_first_oe(tpf_oe),
      .tx_pin_alt(tpa), .tx_pin_alt_oe(tpa_oe), .clk_pin_first(cpf), .clk_pin_first_oe(cpf_oe),
      .clk_pin_alt(cpa), .clk_pin_alt_oe(cpa_oe), .transmit_enable(), .receive_enable(),
      .continuous_rx_enable(), .serial_mode(), .tx_request(txrq));
   remote_serial_model remote_serial_model_i (.rx_pin_first(rx_pf), .rx_pin_alt(rx_pa),
      .clk_pin_first_in(ck_pf), .clk_pin_alt_in(ck_pa));
   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic finish_test();
      if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One bus access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= d;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      rd = readdata;
      rsp = response;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic rx(input logic [8:0] d, input logic o, input logic f, input logic p);
      @(posedge ref_clk);
      {rx_done, rx_data, rx_ovr, rx_frm, rx_par} <= {1'b1, d, o, f, p};
      @(posedge ref_clk);
      rx_done <= 1'b0;
   endtask
   // Timeout
   initial begin
      #100000;
      err_total++;
      finish_test();
   end
   // Main sequence
   initial begin
      {reset, read, write, tx_load, tx_take, shift_empty} = 6'h21;
      {address, writedata, rx_done, rx_data, rx_ovr, rx_frm, rx_par} = '0;
      {tx_ser, ck_out} = 2'b00;
      err_total = 0;
      n_compared = 0;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      rdchk(12'h294, 32'h02);
      rdchk(12'h620, 32'h00);
      bus(1'b0, 12'h004, 32'h0);
      chk(rsp, 32'h3);
      // Routing is set after the reset and unmapped checks, every code in turn
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, 12'h620, 32'h15 * k);
         {tx_ser, ck_out} <= 2'(k);
         wt(4);
         chk({tpf, tpa, cpf, cpa}, {k[1], k[1], k[0], k[0]});
         chk({tpf_oe, tpa_oe}, {k == 1, k == 2});
         chk({rx_serial, clk_in}, k == 1 ? 2'b01 : k == 2 ? 2'b10 : 2'b11);
         chk({cpf_oe, cpa_oe}, {k == 1, k == 2});
      end
      bus(1'b1, 12'h280, 32'h0);
      bus(1'b1, 12'h294, 32'hFD);
      rdchk(12'h294, 32'h37);
      bus(1'b1, 12'h294, 32'h05);
      @(posedge ref_clk) tx_load <= 1'b1;
      @(posedge ref_clk) tx_load <= 1'b0;
      rdchk(12'h294, 32'h05);
      wt(1);
      chk(txrq, 32'h0);
      @(posedge ref_clk) tx_take <= 1'b1;
      @(posedge ref_clk) tx_take <= 1'b0;
      rdchk(12'h294, 32'h07);
      wt(1);
      chk(txrq, 32'h1);
      bus(1'b1, 12'h294, 32'h15);
      @(posedge ref_clk) shift_empty <= 1'b0;
      wt(3);
      chk(txrq, 32'h0);
      @(posedge ref_clk) shift_empty <= 1'b1;
      wt(3);
      chk(txrq, 32'h1);
      // Receive flags, whole 16-bit reads only
      rx(9'h1A5, 1'b0, 1'b1, 1'b0);
      rdchk(12'h294, 32'h1F);
      rdchk(12'h298, 32'hA1A5);
      rdchk(12'h298, 32'h01A5);
      rdchk(12'h294, 32'h17);
      rx(9'h05A, 1'b1, 1'b0, 1'b1);
      rdchk(12'h298, 32'hD05A);
      rdchk(12'h298, 32'h905A);
      bus(1'b1, 12'h294, 32'h11);
      rdchk(12'h298, 32'h005A);
      finish_test();
   end
endmodule
`default_nettype wire
